// >>> shared/oms_regs.svh
// register offsets, field positions, reset values for the operating mode select block
// assumes byte-wide register port with 20-bit address
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH
`define OMS_ADDR_W 20
`define OMS_MODE_RB_OFS 20'hEE011
`define OMS_SYSCTL_OFS 20'hEE012
`define OMS_AREA_W_OFS 20'hEE020
`define OMS_SYSCTL_RST 8'h09
`define OMS_AREA_W_RST 8'hFF
`define OMS_SYSCTL_RAMEN 0
`define OMS_MODE_RB_TOP 8'hC0
`endif

// >>> shared/oms_pkg.sv
// types for the operating mode select block
// assumes nothing beyond the register header
package oms_pkg;
  typedef enum logic [2:0] {
    OMS_MODE_BAD = 3'h0,
    OMS_MODE_1 = 3'h1,
    OMS_MODE_2 = 3'h2,
    OMS_MODE_3 = 3'h3,
    OMS_MODE_4 = 3'h4,
    OMS_MODE_5 = 3'h5,
    OMS_MODE_6 = 3'h6,
    OMS_MODE_7 = 3'h7
  } oms_mode_t;
  typedef enum logic [1:0] {
    OMS_SPACE_64K = 2'h0,
    OMS_SPACE_1M = 2'h1,
    OMS_SPACE_16M = 2'h2
  } oms_space_t;
endpackage

// >>> hdl/oms_top.sv
// operating mode decode, mode readback and system control registers
// assumes mode pins synchronous and steady during operation; byte register port
`timescale 1ns/1ns
`include "oms_regs.svh"
module oms_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // mode straps
  input wire logic [2:0] mode_select_pins,
  // register port
  input wire logic [`OMS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // decoded mode and register outputs
  output logic [2:0] mode_num,
  output logic mode_valid,
  output logic [1:0] addr_space,
  output logic ext_bus_en,
  output logic int_rom_en,
  output logic ports_general,
  output logic bus_16bit,
  output logic ram_to_ext,
  output logic [7:0] area_16bit,
  output logic [7:0] system_control
);
  oms_pkg::oms_mode_t mode_q;
  logic [7:0] sysctl_q;
  logic [7:0] area_w_q;
  logic [7:0] rdata_q;
  logic expanded;

  // mode is taken continuously: pins must hold steady anyway
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= oms_pkg::OMS_MODE_BAD;
    end else if (clk_en) begin
      mode_q <= oms_pkg::oms_mode_t'(mode_select_pins);
    end
  end

  assign expanded = (mode_q >= oms_pkg::OMS_MODE_1) && (mode_q <= oms_pkg::OMS_MODE_5);

  always_comb begin
    mode_num = mode_q;
    mode_valid = 1'b1;
    addr_space = oms_pkg::OMS_SPACE_16M;
    ext_bus_en = 1'b0;
    int_rom_en = 1'b0;
    ports_general = 1'b0;
    unique case (mode_q)
      oms_pkg::OMS_MODE_1, oms_pkg::OMS_MODE_2: begin
        addr_space = oms_pkg::OMS_SPACE_1M;
        ext_bus_en = 1'b1;
      end
      oms_pkg::OMS_MODE_3, oms_pkg::OMS_MODE_4: begin
        addr_space = oms_pkg::OMS_SPACE_16M;
        ext_bus_en = 1'b1;
      end
      oms_pkg::OMS_MODE_5: begin
        addr_space = oms_pkg::OMS_SPACE_16M;
        ext_bus_en = 1'b1;
        int_rom_en = 1'b1;
      end
      oms_pkg::OMS_MODE_6: begin
        addr_space = oms_pkg::OMS_SPACE_64K;
        int_rom_en = 1'b1;
        ports_general = 1'b1;
      end
      oms_pkg::OMS_MODE_7: begin
        addr_space = oms_pkg::OMS_SPACE_1M;
        int_rom_en = 1'b1;
        ports_general = 1'b1;
      end
      default: begin
        // all-zero code is illegal on the board side
        mode_valid = 1'b0;
      end
    endcase
  end

  // width register: one bit per area, 1 = 8-bit; only meaningful when expanded
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      area_w_q <= `OMS_AREA_W_RST;
    end else if (clk_en && reg_wr && reg_addr == `OMS_AREA_W_OFS) begin
      area_w_q <= reg_wdata;
    end
  end

  // initial width from mode follows from the reset value of area_w_q being
  // overridden here: modes 2 and 4 start all areas at 16-bit
  logic init_done_q;
  logic [7:0] area_eff;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      init_done_q <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == `OMS_AREA_W_OFS) begin
      init_done_q <= 1'b1;
    end
  end
  always_comb begin
    area_eff = area_w_q;
    if (!init_done_q && (mode_q == oms_pkg::OMS_MODE_2 || mode_q == oms_pkg::OMS_MODE_4)) begin
      area_eff = 8'h00;
    end
  end
  assign area_16bit = expanded ? ~area_eff : 8'h00;
  assign bus_16bit = expanded && (area_eff != 8'hFF);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sysctl_q <= `OMS_SYSCTL_RST;
    end else if (clk_en && reg_wr && reg_addr == `OMS_SYSCTL_OFS) begin
      sysctl_q <= reg_wdata;
    end
  end
  assign system_control = sysctl_q;
  assign ram_to_ext = expanded && !sysctl_q[`OMS_SYSCTL_RAMEN];

  // read data registered; pins sampled in the read cycle itself
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `OMS_MODE_RB_OFS: rdata_q <= `OMS_MODE_RB_TOP | {5'h00, mode_select_pins};
          `OMS_SYSCTL_OFS: rdata_q <= sysctl_q;
          `OMS_AREA_W_OFS: rdata_q <= area_w_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  a_rb_top_bits: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == `OMS_MODE_RB_OFS |=> reg_rdata[7:6] == 2'h3)
    else $error("readback top bits not one");
  a_rb_mid_bits: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == `OMS_MODE_RB_OFS |=> reg_rdata[5:3] == 3'h0)
    else $error("readback middle bits not zero");
  a_rb_pin_sample: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == `OMS_MODE_RB_OFS |=> reg_rdata[2:0] == $past(mode_select_pins))
    else $error("readback pins mismatch");
  a_rb_write_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == `OMS_MODE_RB_OFS |=> $stable(sysctl_q) && $stable(area_w_q))
    else $error("readback write had effect");
  a_sysctl_write: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == `OMS_SYSCTL_OFS |=> system_control == $past(reg_wdata))
    else $error("system control write lost");
  a_rom_block: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h1, 3'h2, 3'h3, 3'h4} |-> ext_bus_en && !int_rom_en)
    else $error("rom reachable in expanded mode");
  a_space_size: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h1, 3'h2, 3'h7} |-> addr_space == oms_pkg::OMS_SPACE_1M)
    else $error("space not 1 Mbyte");
  a_single_chip: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == 3'h6 |-> ports_general && !ext_bus_en && addr_space == oms_pkg::OMS_SPACE_64K)
    else $error("single chip mode wrong");
  a_ram_route: assert property (@(posedge sys_clk) disable iff (reset)
    expanded && !sysctl_q[0] |-> ram_to_ext)
    else $error("ram not routed outside");
  a_mode_follow: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en |=> mode_num == $past(mode_select_pins))
    else $error("mode not from pins");
  a_bus8_mode: assert property (@(posedge sys_clk) disable iff (reset)
    area_eff == 8'hFF |-> !bus_16bit)
    else $error("all-8-bit not in 8-bit mode");

  // register port steps, shared by the read, write and freeze checks below
  // reads are split by target so each answer is checked against its own source
  sequence s_rb_read;
    clk_en && reg_rd && reg_addr == `OMS_MODE_RB_OFS;
  endsequence

  sequence s_sc_read;
    clk_en && reg_rd && reg_addr == `OMS_SYSCTL_OFS;
  endsequence

  sequence s_aw_read;
    clk_en && reg_rd && reg_addr == `OMS_AREA_W_OFS;
  endsequence

  sequence s_other_read;
    clk_en && reg_rd && !(reg_addr inside {`OMS_MODE_RB_OFS, `OMS_SYSCTL_OFS, `OMS_AREA_W_OFS});
  endsequence

  sequence s_idle;
    clk_en && !reg_rd;
  endsequence

  sequence s_frozen;
    !clk_en;
  endsequence

  sequence s_aw_write;
    clk_en && reg_wr && reg_addr == `OMS_AREA_W_OFS;
  endsequence

  sequence s_rb_write;
    clk_en && reg_wr && reg_addr == `OMS_MODE_RB_OFS;
  endsequence

  a_sc_read: assert property (@(posedge sys_clk) disable iff (reset)
    s_sc_read
    |=> reg_rdata == $past(sysctl_q))
    else $error("system control read wrong");

  a_area_read: assert property (@(posedge sys_clk) disable iff (reset)
    s_aw_read
    |=> reg_rdata == $past(area_w_q))
    else $error("area width read wrong");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (reset)
    s_other_read
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
    s_idle
    |=> reg_rdata == 8'h00)
    else $error("read data without read");

  a_rb_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    s_rb_read ##1 s_idle
    |=> reg_rdata == 8'h00)
    else $error("readback stands too long");

  a_rb_full: assert property (@(posedge sys_clk) disable iff (reset)
    s_rb_read
    |=> reg_rdata == (8'hC0 | {5'h00, $past(mode_select_pins)}))
    else $error("readback byte wrong");

  a_rdata_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    s_frozen
    |=> $stable(reg_rdata))
    else $error("read data moved while frozen");

  a_sysctl_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    s_frozen
    |=> $stable(sysctl_q))
    else $error("system control moved while frozen");

  a_area_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    s_frozen
    |=> $stable(area_w_q))
    else $error("area width moved while frozen");

  a_mode_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    s_frozen
    |=> $stable(mode_q))
    else $error("mode moved while frozen");

  a_area_write: assert property (@(posedge sys_clk) disable iff (reset)
    s_aw_write
    |=> area_w_q == $past(reg_wdata))
    else $error("area width write lost");

  a_sysctl_ignore: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr != `OMS_SYSCTL_OFS
    |=> $stable(sysctl_q))
    else $error("system control hit by other write");

  a_area_ignore: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr != `OMS_AREA_W_OFS
    |=> $stable(area_w_q))
    else $error("area width hit by other write");

  a_frozen_write: assert property (@(posedge sys_clk) disable iff (reset)
    !clk_en && reg_wr
    |=> $stable(sysctl_q) && $stable(area_w_q))
    else $error("write taken while frozen");

  a_rb_no_init: assert property (@(posedge sys_clk) disable iff (reset)
    s_rb_write
    |=> $stable(init_done_q))
    else $error("readback write changed width state");

  a_init_clear: assert property (@(posedge sys_clk) disable iff (reset)
    s_aw_write
    |=> init_done_q)
    else $error("initial width not released");

  a_valid_code: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q != oms_pkg::OMS_MODE_BAD
    |-> mode_valid)
    else $error("valid mode flagged bad");

  a_bad_code: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == oms_pkg::OMS_MODE_BAD
    |-> !mode_valid)
    else $error("zero code flagged valid");

  a_mode5_both: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == 3'h5
    |-> ext_bus_en && int_rom_en && addr_space == oms_pkg::OMS_SPACE_16M)
    else $error("mode 5 access wrong");

  a_space_16m: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h3, 3'h4}
    |-> addr_space == oms_pkg::OMS_SPACE_16M)
    else $error("space not 16 Mbyte");

  a_mode7_chip: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == 3'h7
    |-> ports_general && !ext_bus_en && int_rom_en)
    else $error("mode 7 not single chip");

  a_mode6_space: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == 3'h6
    |-> addr_space == oms_pkg::OMS_SPACE_64K)
    else $error("mode 6 space wrong");

  a_mode7_space: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == 3'h7
    |-> addr_space == oms_pkg::OMS_SPACE_1M)
    else $error("mode 7 space wrong");

  a_ports_expanded: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}
    |-> !ports_general)
    else $error("ports freed in expanded mode");

  a_single_no16: assert property (@(posedge sys_clk) disable iff (reset)
    !expanded
    |-> !bus_16bit && area_16bit == 8'h00)
    else $error("bus width outside expanded mode");

  a_init_16bit: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h2, 3'h4} && !init_done_q
    |-> bus_16bit && area_16bit == 8'hFF)
    else $error("initial 16-bit bus missing");

  a_init_8bit: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h1, 3'h3, 3'h5} && area_w_q == 8'hFF
    |-> !bus_16bit)
    else $error("initial 8-bit bus missing");

  a_area_map: assert property (@(posedge sys_clk) disable iff (reset)
    expanded && init_done_q
    |-> area_16bit == ~area_w_q)
    else $error("area width map wrong");

  a_ram_internal: assert property (@(posedge sys_clk) disable iff (reset)
    sysctl_q[`OMS_SYSCTL_RAMEN]
    |-> !ram_to_ext)
    else $error("ram routed out while enabled");

  a_ram_single: assert property (@(posedge sys_clk) disable iff (reset)
    !expanded
    |-> !ram_to_ext)
    else $error("ram routed out in single chip");

  a_ext_single: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q inside {3'h6, 3'h7}
    |-> !ext_bus_en && !bus_16bit)
    else $error("external bus in single chip");

  a_bus16_some: assert property (@(posedge sys_clk) disable iff (reset)
    expanded && area_eff != 8'hFF
    |-> bus_16bit)
    else $error("16-bit area without 16-bit bus");
endmodule

// >>> tb/oms_strap.sv
// strap model: board-level levels on the mode select pins
// assumes the bench changes the code only while reset is held
`timescale 1ns/1ns
module oms_strap (
  // requested code
  input wire logic [2:0] code,
  // strap levels
  output logic [2:0] mode_select_pins
);
  // a board never straps code 0, so fall back to mode 7
  assign mode_select_pins = (code == 3'h0) ? 3'h7 : code;
endmodule

// >>> tb/tb.sv
// self-checking bench for the operating mode select block
// assumes straps move only under reset, byte register port
`timescale 1ns/1ns
`include "oms_regs.svh"
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] code = 3'h1;
  logic [2:0] pins, mode_num;
  logic [`OMS_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, area_16bit, system_control, rd;
  logic [1:0] addr_space;
  logic mode_valid, ext_bus_en, int_rom_en, ports_general, bus_16bit, ram_to_ext;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 sys_clk = ~sys_clk;
  oms_strap u_strap (.code(code), .mode_select_pins(pins));
  oms_top u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .mode_select_pins(pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_num(mode_num),
    .mode_valid(mode_valid), .addr_space(addr_space), .ext_bus_en(ext_bus_en),
    .int_rom_en(int_rom_en), .ports_general(ports_general), .bus_16bit(bus_16bit),
    .ram_to_ext(ram_to_ext), .area_16bit(area_16bit), .system_control(system_control));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [19:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // generous ceiling: seven modes of some twenty-six cycles each
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    for (int m = 1; m < 8; m++) begin
      @(posedge sys_clk);
      reset <= 1'b1;
      code <= 3'(m);
      repeat (5) @(posedge sys_clk);
      chk("mode_valid reset", 8'h00, {7'h00, mode_valid});
      reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("mode_num", 8'(m), {5'h00, mode_num});
      chk("mode_valid", 8'h01, {7'h00, mode_valid});
      chk("addr_space", (m == 6) ? 8'h00 : (m > 2 && m < 6) ? 8'h02 : 8'h01,
        {6'h00, addr_space});
      chk("ext_bus_en", 8'(m < 6), {7'h00, ext_bus_en});
      chk("int_rom_en", 8'(m > 4), {7'h00, int_rom_en});
      chk("ports_general", 8'(m > 5), {7'h00, ports_general});
      chk("bus_16bit", 8'(m == 2 || m == 4), {7'h00, bus_16bit});
      wr(`OMS_MODE_RB_OFS, 8'h3F);
      rdr(`OMS_MODE_RB_OFS);
      chk("readback", `OMS_MODE_RB_TOP | 8'(m), rd);
      rdr(`OMS_SYSCTL_OFS);
      chk("sysctl reset", `OMS_SYSCTL_RST, rd);
      wr(`OMS_SYSCTL_OFS, 8'h08);
      clk_en <= 1'b0;
      wr(`OMS_SYSCTL_OFS, 8'h55);
      clk_en <= 1'b1;
      rdr(`OMS_SYSCTL_OFS);
      chk("sysctl rw", 8'h08, rd);
      chk("system_control", 8'h08, system_control);
      chk("ram_to_ext", 8'(m < 6), {7'h00, ram_to_ext});
      wr(`OMS_AREA_W_OFS, 8'hFE);
      chk("area_16bit", (m < 6) ? 8'h01 : 8'h00, area_16bit);
      chk("bus_16bit area", 8'(m < 6), {7'h00, bus_16bit});
      wr(`OMS_AREA_W_OFS, 8'hFF);
      chk("bus_16bit all 8", 8'h00, {7'h00, bus_16bit});
      rdr(20'hEE013);
      chk("unmapped", 8'h00, rd);
    end
    test_done();
  end
endmodule
